// file: logic/rse_store_report.sv
// reading store, readout and event reporting behind an AXI4-Lite slave
`timescale 1ns/1ps
`include "rse_cfg.svh"
module rse_store_report #(
  parameter int MS_CYCLES = `RSE_MS_NS / `RSE_CLK_NS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire rse_pkg::rse_conv_t conv,
  output logic conv_start,
  input wire logic identify_key,
  output logic srq
);
  // byte-lane merge of a write into an old word
  function automatic logic [31:0] rse_merge(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction : rse_merge

  // pointer step that returns to zero at the limit
  function automatic logic [8:0] rse_inc(input logic [8:0] p, input logic [8:0] lim);
    return (p + 9'h001 >= lim) ? 9'h000 : p + 9'h001;
  endfunction : rse_inc

  function automatic logic [7:0] rse_code(input logic [`RSE_EV_N-1:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = `RSE_EV_N - 1; i >= 0; i--) begin
      if (v[i]) c = 8'(i + 1);
    end
    return c;
  endfunction : rse_code

  rse_pkg::rse_ctrl_t ctrl_reg;
  logic [`RSE_IVAL_W-1:0] ival_reg, ms_left_reg;
  logic [31:0] ms_cnt_reg;
  logic due_reg;
  logic signed [23:0] mem [`RSE_DEPTH_N];
  logic [8:0] wr_ptr_reg, count_reg, rd_ptr_reg;
  logic signed [33:0] sum_reg;
  logic signed [23:0] min_reg, max_reg, last_reg;
  logic last_over_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  rse_pkg::rse_rd_t rd_st_reg;
  logic [7:0] ra_reg;
  logic ra_hi_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  rse_pkg::rse_info_t info_reg;
  logic [7:0] pend_reg;
  logic trig_req_reg, run_reg, busy_reg, conv_start_reg;
  logic key_s1_reg, key_s2_reg, key_s3_reg;
  logic [`RSE_EV_N-1:0] ev_reg, ev_next, ev_set, ev_clr;
  logic srq_reg;

  // write channel: address and data are taken together, one write at a time
  wire wr_take = awvalid && wvalid && !bvalid_reg;
  wire wa_ok = awaddr[31:8] == 24'h000000;
  wire wr_ctrl = wr_take && wa_ok && awaddr[7:0] == `RSE_A_CTRL;
  wire wr_ival = wr_take && wa_ok && awaddr[7:0] == `RSE_A_IVAL;
  wire wr_cmd = wr_take && wa_ok && awaddr[7:0] == `RSE_A_CMD;
  wire wr_known = wr_ctrl || wr_ival || wr_cmd;
  wire wr_clear = wr_ctrl && (wstrb[0] || wstrb[1]);
  wire trig_cmd = wr_cmd && wstrb[0] && wdata[`RSE_CMD_TRIG];
  wire send_cmd = wr_cmd && wstrb[0] && wdata[`RSE_CMD_SEND];
  wire bdone = bvalid_reg && bready;
  assign awready = wr_take;
  assign wready = wr_take;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;

  wire circ = ctrl_reg.size == 9'h000;
  wire [8:0] cap = (circ || ctrl_reg.size > `RSE_DEPTH) ? `RSE_DEPTH : ctrl_reg.size;
  wire [8:0] half_pt = 9'((10'(cap) + 10'h001) >> 1);
  wire lin_full = !circ && count_reg == cap;
  wire stat_ok = count_reg == cap;
  wire ival_zero = ival_reg == '0;
  wire ms_tick = ms_cnt_reg == 32'(MS_CYCLES - 1);
  wire interval_hit = !ival_zero && ms_tick && ms_left_reg <= 20'h00001;
  wire store = conv.valid && (ival_zero || due_reg) && !lin_full;
  wire ring_full = circ && count_reg == `RSE_DEPTH;
  wire signed [23:0] old_w = ring_full ? mem[wr_ptr_reg] : 24'sh000000;
  wire first_w = count_reg == 9'h000;

  // storage interval timer; zero interval means one store per conversion
  always_ff @(posedge aclk) begin
    if (!aresetn || ival_zero) begin
      ms_cnt_reg <= 32'h00000000;
      ms_left_reg <= ival_reg;
      due_reg <= 1'b0;
    end else begin
      ms_cnt_reg <= ms_tick ? 32'h00000000 : ms_cnt_reg + 32'h00000001;
      if (ms_tick) ms_left_reg <= interval_hit ? ival_reg : ms_left_reg - 20'h00001;
      // a new interval wins over consuming the old one
      due_reg <= interval_hit || (due_reg && !store);
    end
  end

  // reading memory has no reset; count bounds what is valid
  always_ff @(posedge aclk) begin
    if (store) mem[wr_ptr_reg] <= conv.data;
  end

  // write pointer, fill count and running statistics
  always_ff @(posedge aclk) begin
    if (!aresetn || wr_clear) begin
      wr_ptr_reg <= 9'h000;
      count_reg <= 9'h000;
      sum_reg <= 34'sh0;
      min_reg <= 24'sh000000;
      max_reg <= 24'sh000000;
    end else if (store) begin
      wr_ptr_reg <= rse_inc(wr_ptr_reg, `RSE_DEPTH);
      count_reg <= ring_full ? count_reg : count_reg + 9'h001;
      sum_reg <= sum_reg + 34'(conv.data) - 34'(old_w);
      // min and max follow every stored reading since the last clear
      min_reg <= (first_w || conv.data < min_reg) ? conv.data : min_reg;
      max_reg <= (first_w || conv.data > max_reg) ? conv.data : max_reg;
    end
  end

  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `RSE_CTRL_RST;
      ival_reg <= '0;
    end else begin
      if (wr_ctrl) ctrl_reg <= rse_merge(ctrl_reg, wdata, wstrb);
      if (wr_ival) ival_reg <= `RSE_IVAL_W'(rse_merge(32'(ival_reg), wdata, wstrb));
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `RSE_RESP_OK;
    end else if (wr_take) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_known ? `RSE_RESP_OK : `RSE_RESP_ERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  wire start_go = !busy_reg && !conv_start_reg && (trig_req_reg || (run_reg && ctrl_reg.continuous_trigger));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_req_reg <= 1'b0;
      run_reg <= 1'b0;
      busy_reg <= 1'b0;
      conv_start_reg <= 1'b0;
    end else begin
      trig_req_reg <= trig_cmd || send_cmd || (trig_req_reg && !start_go);
      run_reg <= ctrl_reg.continuous_trigger && (run_reg || trig_cmd);
      conv_start_reg <= start_go;
      busy_reg <= conv_start_reg || (busy_reg && !conv.valid);
    end
  end
  assign conv_start = conv_start_reg;

  // latest converter reading for direct talk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_reg <= 24'sh000000;
      last_over_reg <= 1'b0;
    end else if (conv.valid) begin
      last_reg <= conv.data;
      last_over_reg <= conv.over;
    end
  end

  // read channel decode
  wire ra_stat = ra_reg == `RSE_A_AVG || ra_reg == `RSE_A_MIN || ra_reg == `RSE_A_MAX;
  wire rd_fire = rd_st_reg == rse_pkg::RD_WAIT && (ra_hi_reg || !ra_stat || stat_ok);
  wire rd_data = rd_fire && !ra_hi_reg && ra_reg == `RSE_A_DATA;
  wire rd_evq = rd_fire && !ra_hi_reg && ra_reg == `RSE_A_EVQ;
  wire rd_poll = rd_fire && !ra_hi_reg && ra_reg == `RSE_A_POLL;
  wire ra_known = !ra_hi_reg && (ra_stat || ra_reg == `RSE_A_CTRL || ra_reg == `RSE_A_IVAL ||
    ra_reg == `RSE_A_STAT || ra_reg == `RSE_A_DATA || ra_reg == `RSE_A_INFO ||
    ra_reg == `RSE_A_EVQ || ra_reg == `RSE_A_POLL);

  wire src_adc = ctrl_reg.src == rse_pkg::SRC_ADC;
  wire src_all = ctrl_reg.src == rse_pkg::SRC_ALL;
  wire have = rd_ptr_reg < count_reg;
  wire [23:0] out_val = src_adc ? last_reg : (have ? mem[rd_ptr_reg] : `RSE_EMPTY);
  wire [8:0] out_loc = (src_adc || !have) ? 9'h000 : rd_ptr_reg + 9'h001;
  wire rewind = src_all && rse_inc(rd_ptr_reg, count_reg) == 9'h000;
  wire [31:0] avg_w = 32'(sum_reg / $signed({25'h0, count_reg}));

  rse_pkg::rse_status_t stat_w;
  assign stat_w = '{rsv: 8'h00, pend: pend_reg, rsv2: 4'h0, busy: busy_reg,
                    half: count_reg >= half_pt, full: stat_ok,
                    cnt: circ ? wr_ptr_reg : count_reg};

  wire [31:0] rd_mux = !ra_known ? 32'h00000000 :
    ra_reg == `RSE_A_CTRL ? 32'(ctrl_reg) :
    ra_reg == `RSE_A_IVAL ? 32'(ival_reg) :
    ra_reg == `RSE_A_STAT ? 32'(stat_w) :
    ra_reg == `RSE_A_DATA ? 32'($signed(out_val)) :
    ra_reg == `RSE_A_INFO ? 32'(info_reg) :
    ra_reg == `RSE_A_EVQ ? 32'(rse_code(ev_reg)) :
    ra_reg == `RSE_A_POLL ? {25'h0, srq_reg, ev_reg} :
    ra_reg == `RSE_A_AVG ? avg_w :
    ra_reg == `RSE_A_MIN ? 32'(min_reg) : 32'(max_reg);

  // read state machine: idle, wait for data, respond
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_st_reg <= rse_pkg::RD_IDLE;
      ra_reg <= 8'h00;
      ra_hi_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `RSE_RESP_OK;
    end else begin
      unique case (rd_st_reg)
        rse_pkg::RD_IDLE: begin
          if (arvalid) begin
            rd_st_reg <= rse_pkg::RD_WAIT;
            ra_reg <= araddr[7:0];
            ra_hi_reg <= araddr[31:8] != 24'h000000;
          end
        end
        rse_pkg::RD_WAIT: begin
          if (rd_fire) begin
            rd_st_reg <= rse_pkg::RD_RESP;
            rdata_reg <= rd_mux;
            rresp_reg <= ra_known ? `RSE_RESP_OK : `RSE_RESP_ERR;
          end
        end
        rse_pkg::RD_RESP: begin
          if (rready) rd_st_reg <= rse_pkg::RD_IDLE;
        end
        default: rd_st_reg <= rse_pkg::RD_IDLE;
      endcase
    end
  end
  assign arready = rd_st_reg == rse_pkg::RD_IDLE;
  assign rvalid = rd_st_reg == rse_pkg::RD_RESP;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // readout pointer and queued talk requests
  always_ff @(posedge aclk) begin
    if (!aresetn || wr_clear) begin
      rd_ptr_reg <= 9'h000;
      info_reg <= '0;
    end else if (rd_data) begin
      if (!src_adc && have) rd_ptr_reg <= rewind ? 9'h000 : rd_ptr_reg + 9'h001;
      info_reg <= '{rsv: '0, valid: ctrl_reg.fmt_en,
                    over: ctrl_reg.fmt_en && src_adc && last_over_reg,
                    loc: ctrl_reg.fmt_en ? out_loc : 9'h000};
    end
  end

  wire pend_dec = rd_data && pend_reg != 8'h00;
  always_ff @(posedge aclk) begin
    if (!aresetn) pend_reg <= 8'h00;
    else if (send_cmd && !pend_dec && pend_reg != `RSE_PEND_MAX) pend_reg <= pend_reg + 8'h01;
    else if (pend_dec && !send_cmd) pend_reg <= pend_reg - 8'h01;
  end

  // identify key pin synchroniser and edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_s1_reg <= 1'b0;
      key_s2_reg <= 1'b0;
      key_s3_reg <= 1'b0;
    end else begin
      key_s1_reg <= identify_key;
      key_s2_reg <= key_s1_reg;
      key_s3_reg <= key_s2_reg;
    end
  end
  wire key_edge = key_s2_reg && !key_s3_reg;

  // event sources, all gated by the error report enable
  always_comb begin
    ev_set = '0;
    ev_set[`RSE_EV_OVER] = ctrl_reg.over_en && conv.valid && conv.over;
    ev_set[`RSE_EV_FULL] = ctrl_reg.full_en && store && !circ && count_reg + 9'h001 == cap;
    ev_set[`RSE_EV_HALF] = ctrl_reg.half_en && store && !circ && count_reg + 9'h001 == half_pt;
    ev_set[`RSE_EV_OPC] = ctrl_reg.opc_en && conv.valid;
    ev_set[`RSE_EV_RDY] = ctrl_reg.rdy_en && (conv.valid || bdone) && !trig_req_reg;
    ev_set[`RSE_EV_USER] = ctrl_reg.user_en && key_edge;
    if (!ctrl_reg.err_en) ev_set = '0;
  end

  assign ev_clr = rd_poll ? ev_reg : (rd_evq ? (ev_reg & (~ev_reg + 1'b1)) : '0);
  // a new event in the clearing cycle survives
  assign ev_next = (ev_reg & ~ev_clr) | ev_set;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_reg <= '0;
      srq_reg <= 1'b0;
    end else begin
      ev_reg <= ev_next;
      srq_reg <= ctrl_reg.rqs_en && |ev_next && !wr_take;
    end
  end
  assign srq = srq_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_stat_blocked;
    rd_st_reg == rse_pkg::RD_WAIT && !ra_hi_reg && ra_stat && !stat_ok;
  endsequence
  sequence s_last_all;
    rd_data && src_all && have && rd_ptr_reg + 9'h001 == count_reg;
  endsequence

  a_ring_wrap: assert property (store && circ && wr_ptr_reg == `RSE_LAST && !wr_clear
    |=> wr_ptr_reg == 9'h000) else $error("ring pointer did not wrap");
  a_lin_bound: assert property (!circ |-> count_reg <= cap)
    else $error("linear count beyond capacity");
  a_lin_drop: assert property (conv.valid && lin_full && !wr_clear
    |=> $stable(count_reg) && $stable(wr_ptr_reg)) else $error("full linear store changed");
  a_clear_ptrs: assert property (wr_clear
    |=> count_reg == 9'h000 && wr_ptr_reg == 9'h000 && rd_ptr_reg == 9'h000)
    else $error("size write did not clear store");
  a_stat_hold: assert property (s_stat_blocked |=> !rvalid)
    else $error("statistics answered before full");
  a_all_rewind: assert property (s_last_all ##1 !wr_clear |-> rd_ptr_reg == 9'h000)
    else $error("all-stored readout did not rewind");
  a_evq_zero: assert property (rd_evq && ev_reg == '0 ##1 rvalid |-> rdata == 32'h0)
    else $error("empty event query not zero");
  a_srq_off: assert property (!ctrl_reg.rqs_en |=> !srq)
    else $error("service request while disabled");
  a_full_evt: assert property (ev_set[`RSE_EV_FULL] |=> ev_reg[`RSE_EV_FULL])
    else $error("full event lost");
  a_start_busy: assert property (conv_start |=> busy_reg && !conv_start)
    else $error("conversion start not followed by busy");
endmodule : rse_store_report

// file: logic/rse_cfg.svh
// constants for the reading store and event report block
`ifndef RSE_CFG_SVH
`define RSE_CFG_SVH
`define RSE_DEPTH 9'h1f4
`define RSE_DEPTH_N 500
`define RSE_LAST 9'h1f3
`define RSE_CLK_NS 20
`define RSE_MS_NS 1000000
`define RSE_IVAL_W 20
`define RSE_A_CTRL 8'h00
`define RSE_A_IVAL 8'h04
`define RSE_A_CMD 8'h08
`define RSE_A_STAT 8'h0c
`define RSE_A_DATA 8'h10
`define RSE_A_INFO 8'h14
`define RSE_A_EVQ 8'h18
`define RSE_A_POLL 8'h1c
`define RSE_A_AVG 8'h20
`define RSE_A_MIN 8'h24
`define RSE_A_MAX 8'h28
`define RSE_CMD_TRIG 0
`define RSE_CMD_SEND 1
`define RSE_RESP_OK 2'b00
`define RSE_RESP_ERR 2'b10
`define RSE_CTRL_RST 32'h00006000
`define RSE_EMPTY 24'h800000
`define RSE_EV_N 6
`define RSE_EV_OVER 0
`define RSE_EV_FULL 1
`define RSE_EV_HALF 2
`define RSE_EV_OPC 3
`define RSE_EV_RDY 4
`define RSE_EV_USER 5
`define RSE_PEND_MAX 8'hff
`endif

// file: logic/rse_pkg.sv
// types for the reading store and event report block
package rse_pkg;
  typedef enum logic [1:0] {SRC_ADC = 2'b00, SRC_NEXT = 2'b01, SRC_ALL = 2'b10} rse_src_t;
  typedef enum logic [1:0] {RD_IDLE = 2'b00, RD_WAIT = 2'b01, RD_RESP = 2'b11} rse_rd_t;
  typedef struct packed {
    logic [10:0] rsv;
    logic over_en;
    logic user_en;
    logic rdy_en;
    logic opc_en;
    logic half_en;
    logic full_en;
    logic err_en;
    logic rqs_en;
    logic continuous_trigger;
    logic fmt_en;
    rse_src_t src;
    logic [8:0] size;
  } rse_ctrl_t;
  typedef struct packed {
    logic [7:0] rsv;
    logic [7:0] pend;
    logic [3:0] rsv2;
    logic busy;
    logic half;
    logic full;
    logic [8:0] cnt;
  } rse_status_t;
  typedef struct packed {
    logic [20:0] rsv;
    logic valid;
    logic over;
    logic [8:0] loc;
  } rse_info_t;
  typedef struct packed {
    logic valid;
    logic over;
    logic signed [23:0] data;
  } rse_conv_t;
endpackage : rse_pkg

// file: sim/rse_conv_model.sv
// converter stand-in that answers each start pulse with one queued reading
`timescale 1ns/1ps
module rse_conv_model (
  input wire logic aclk,
  input wire logic conv_start,
  output rse_pkg::rse_conv_t conv
);
  logic [23:0] vals[$];
  logic [23:0] last = 24'h000000;
  bit slow = 1'b0;
  bit ovr = 1'b0; // overrange flag the bench sets for the next result
  initial conv = '0;
  // replies alternate fast and slow; data outside the result pulse is scrambled
  // one result per start
  always @(posedge aclk) begin
    if (conv_start) begin
      slow = !slow;
      repeat (slow ? 6 : 1) @(posedge aclk);
      last = (vals.size() > 0) ? vals.pop_front() : 24'h000000;
      conv <= '{valid: 1'b1, over: ovr, data: last};
      @(posedge aclk);
      conv <= '{valid: 1'b0, over: 1'b0, data: ~last};
    end
  end
endmodule : rse_conv_model

// file: sim/reading_store_event_report_tb_top.sv
// self-checking bench for the reading store and event report block
`timescale 1ns/1ps
`include "rse_cfg.svh"
module reading_store_event_report_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic identify_key = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, conv_start, srq;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] st = 32'h00004cbe;
  logic [23:0] v[$];
  int n_errors = 0, checks_done = 0;
  rse_pkg::rse_conv_t conv;

  rse_store_report #(.MS_CYCLES(4)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .conv(conv),
    .conv_start(conv_start), .identify_key(identify_key), .srq(srq));
  rse_conv_model i_conv (.aclk(aclk), .conv_start(conv_start), .conv(conv));

  // 50 MHz clock
  initial begin
    forever #10 aclk = ~aclk;
  end

  function automatic logic [31:0] rnd();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction : rnd

  function automatic logic [31:0] sx(input logic [23:0] d);
    return {{8{d[23]}}, d};
  endfunction : sx

  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("Error at %0t ns: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // write with address and data offered together, held until taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= {24'h000000, a};
    wdata <= d;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= {24'h000000, a};
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    axr(a, rd, rs);
    chk({rs, rd}, {`RSE_RESP_OK, e});
  endtask : rdchk

  // queue readings and trigger one conversion each, waiting for idle
  task automatic trig(input int n, input bit rep);
    logic [31:0] x;
    for (int i = 0; i < n; i++) begin
      x = rnd();
      if (rep) x[23:0] = v[0];
      v.push_back(x[23:0]);
      i_conv.vals.push_back(x[23:0]);
      axw(`RSE_A_CMD, 32'h00000001, rs);
      do axr(`RSE_A_STAT, rd, rs); while (rd[11] !== 1'b0);
    end
  endtask : trig

  task automatic note(input string s);
    $display("test done: %s", s);
  endtask : note

  task automatic results();
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  // watchdog: the whole sequence needs well under this span
  initial begin
    #(60000 * 20);
    n_errors++;
    results();
  end

  // main sequence
  initial begin
    logic signed [23:0] mn, mx;
    logic [31:0] x;
    logic [1:0] bs;
    int sum;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(`RSE_A_CTRL, `RSE_CTRL_RST); // ring after reset
    axr(8'h40, rd, rs);
    chk({rs, rd}, {`RSE_RESP_ERR, 32'h0});
    axw(`RSE_A_STAT, 32'h0, rs);
    chk({32'h0, rs}, {32'h0, `RSE_RESP_ERR});
    note("map");
    // linear store of four, two extra readings dropped
    // per trigger storing
    axw(`RSE_A_IVAL, 32'h0, rs);
    axw(`RSE_A_CTRL, 32'h0001cc04, rs);
    trig(3, 1'b0);
    // average read is held off until the fourth reading fills the store
    fork
      axr(`RSE_A_AVG, rd, rs);
      begin
        repeat (8) @(posedge aclk);
        x = rnd();
        v.push_back(x[23:0]);
        i_conv.vals.push_back(x[23:0]);
        axw(`RSE_A_CMD, 32'h00000001, bs);
      end
    join
    sum = 0;
    for (int i = 0; i < 4; i++) sum = sum + $signed(v[i]);
    chk({rs, rd}, {`RSE_RESP_OK, 32'(sum / 4)}); // average after full
    trig(2, 1'b1);
    rdchk(`RSE_A_STAT, 32'h00000604); // four held, full
    chk({33'h0, srq}, 34'h0); // queued with request off
    rdchk(`RSE_A_EVQ, 32'h2); // full event first
    rdchk(`RSE_A_EVQ, 32'h3); // half event next
    rdchk(`RSE_A_EVQ, 32'h0); // queue now empty
    mn = v[0];
    mx = v[0];
    for (int i = 1; i < 4; i++) begin
      if ($signed(v[i]) < mn) mn = v[i];
      if ($signed(v[i]) > mx) mx = v[i];
    end
    rdchk(`RSE_A_MIN, sx(mn)); // answered once full
    rdchk(`RSE_A_MAX, sx(mx)); // answered once full
    for (int i = 0; i < 4; i++) begin
      rdchk(`RSE_A_DATA, sx(v[i])); // in order
      rdchk(`RSE_A_INFO, 32'h00000401 + i); // stored location
    end
    rdchk(`RSE_A_DATA, sx(v[0])); // all-stored rewinds to start
    axw(`RSE_A_CTRL, 32'h0001c204, rs);
    rdchk(`RSE_A_STAT, 32'h0); // cleared by size write
    note("linear");
    // ring wraps past the last entry
    v.delete();
    axw(`RSE_A_CTRL, 32'h0001c200, rs);
    trig(`RSE_DEPTH_N + 2, 1'b0);
    axr(`RSE_A_STAT, rd, rs);
    chk({25'h0, rd[8:0]}, {25'h0, 9'h002}); // index after wrap
    rdchk(`RSE_A_EVQ, 32'h0); // ring raises none
    rdchk(`RSE_A_DATA, sx(v[`RSE_DEPTH_N])); // oldest overwritten
    note("ring");
    // converter readout with formatting on
    v.delete();
    axw(`RSE_A_CTRL, 32'h00164800, rs);
    i_conv.ovr = 1'b1;
    trig(1, 1'b0);
    i_conv.ovr = 1'b0;
    rdchk(`RSE_A_DATA, sx(v[0])); // converter source
    rdchk(`RSE_A_INFO, 32'h00000600); // location zero
    rdchk(`RSE_A_EVQ, 32'h1); // overrange event first
    rdchk(`RSE_A_EVQ, 32'h4); // completion event
    rdchk(`RSE_A_EVQ, 32'h5); // ready event
    rdchk(`RSE_A_EVQ, 32'h0); // queue drained
    note("converter");
    // send queues one talk
    i_conv.vals.push_back(24'h5a1c3e);
    axw(`RSE_A_CMD, 32'h00000002, rs);
    do axr(`RSE_A_STAT, rd, rs); while (rd[11] !== 1'b0);
    chk({26'h0, rd[23:16]}, {26'h0, 8'h01}); // one pending
    rdchk(`RSE_A_DATA, 32'h005a1c3e); // pending reading out
    axr(`RSE_A_STAT, rd, rs);
    chk({26'h0, rd[23:16]}, {26'h0, 8'h00}); // pending consumed
    rdchk(`RSE_A_EVQ, 32'h4); // completion after send
    rdchk(`RSE_A_EVQ, 32'h5); // ready after send
    note("send");
    // 3 ms interval with continuous trigger: about one store per 12 cycles
    axw(`RSE_A_CTRL, 32'h00005000, rs);
    axw(`RSE_A_IVAL, 32'h00000003, rs);
    axw(`RSE_A_CMD, 32'h00000001, rs);
    repeat (240) @(posedge aclk);
    axr(`RSE_A_STAT, rd, rs);
    chk({33'h0, rd[8:0] >= 9'h012 && rd[8:0] <= 9'h016}, {33'h0, 1'b1}); // per interval
    axw(`RSE_A_IVAL, 32'h00000000, rs);
    note("interval");
    // identify key with user reporting
    axw(`RSE_A_CTRL, 32'h00086000, rs);
    identify_key <= 1'b1;
    repeat (4) @(posedge aclk);
    identify_key <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({33'h0, srq}, {33'h0, 1'b1}); // request raised
    rdchk(`RSE_A_POLL, 32'h00000060); // poll shows key
    axr(`RSE_A_POLL, rd, rs);
    chk({28'h0, rd[5:0]}, 34'h0); // cleared by poll
    note("key");
    results();
  end
endmodule : reading_store_event_report_tb_top
